// ---- supply_monitor.sv ----
// supply monitor control: clock selection and division, continuous or
// intermittent sampling of the comparator, low count, flag, interrupt and reset.
// assumes the clock generator gives one-cycle source ticks on mclk_in and the
// analog comparator result is a level; APB slave with no wait states.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module supply_monitor (
  input wire logic mclk_in, // bus and core clock, 100 MHz
  input wire logic rst_n_in, // asynchronous reset, active low
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  input wire logic pwrite_in, // apb direction
  input wire logic [7:0] paddr_in, // apb byte address
  input wire logic [31:0] pwdata_in, // apb write data
  output logic [31:0] prdata_out, // apb read data
  output logic pready_out, // apb ready
  output logic pslverr_out, // apb error on unmapped address
  input wire logic [3:0] src_tick_in, // one-cycle ticks of the four clock sources
  input wire logic [3:0] source_sleep_stop_in, // per source: stop in sleep
  input wire logic sleep_in, // cpu in sleep mode
  input wire logic debug_in, // cpu in debug mode
  input wire logic comp_low_in, // comparator: 1 when voltage below threshold
  output logic comp_enable_out, // comparator power
  output logic sense_target_out, // 0 internal supply, 1 external pin
  output logic [4:0] threshold_sel_out, // threshold code to comparator
  output logic irq_out, // low supply interrupt request
  output logic reset_req_out // chip reset request, held while supply low
);
  typedef struct packed {
    logic unlocked;
    logic [1:0] clock_source_sel;
    logic [2:0] clock_divider_sel;
    logic debug_run;
    logic detect_enable;
    logic [1:0] sampling_mode_sel;
    logic [3:0] reset_or_irq_sel;
    logic [4:0] threshold_sel;
    logic [1:0] low_count_sel;
    logic sense_target_sel;
    logic low_supply_flag;
    logic low_supply_irq_enable;
    logic live_low_result;
    logic sync_stage1;
    logic sync_stage2;
    logic [6:0] div_cnt;
    logic [7:0] interval_cnt;
    logic [7:0] slot_cnt;
    logic in_slot;
    logic [3:0] low_cnt;
    logic in_reset;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic comp_enable;
    logic irq;
  } state_s;

  state_s st_reg;
  state_s st_next;

  logic src_tick;
  logic clock_run;
  logic mon_tick;
  logic [6:0] div_limit;
  logic [7:0] interval;
  logic [3:0] count_target;
  logic sample;
  logic detect;
  logic wr_en;
  logic rd_setup;
  logic wr_protect;
  logic wr_clk;
  logic wr_ctrl;
  logic wr_flag;
  logic wr_irq_en;
  logic mapped;
  logic [31:0] rd_word;

  // monitor clock: selected source tick, gated in sleep and debug, then divided
  always_comb begin
    src_tick = src_tick_in[st_reg.clock_source_sel];
    clock_run = !(sleep_in && source_sleep_stop_in[st_reg.clock_source_sel])
      && !(debug_in && !st_reg.debug_run);
    div_limit = 7'((8'h01 << st_reg.clock_divider_sel) - 8'h01);
    mon_tick = src_tick && clock_run && (st_reg.div_cnt >= div_limit);
    case (st_reg.sampling_mode_sel)
      2'h1: interval = supply_monitor_pkg::INTERVAL_MODE1;
      2'h2: interval = supply_monitor_pkg::INTERVAL_MODE2;
      2'h3: interval = supply_monitor_pkg::INTERVAL_MODE3;
      default: interval = supply_monitor_pkg::INTERVAL_MODE1;
    endcase
    count_target = 4'(5'h01 << st_reg.low_count_sel);
  end

  // sample points: every monitor tick when continuous, end of settle in a slot otherwise
  always_comb begin
    if (st_reg.sampling_mode_sel == supply_monitor_pkg::MODE_CONTINUOUS) begin
      sample = st_reg.detect_enable && mon_tick;
    end else begin
      sample = st_reg.detect_enable && mon_tick && st_reg.in_slot
        && (st_reg.slot_cnt >= supply_monitor_pkg::SETTLE_TICKS);
    end
    // the flag event: a low in continuous mode, the n-th successive low otherwise
    if (st_reg.sampling_mode_sel == supply_monitor_pkg::MODE_CONTINUOUS) begin
      detect = sample && st_reg.sync_stage2;
    end else begin
      detect = sample && st_reg.sync_stage2 && (4'(st_reg.low_cnt + 4'h1) >= count_target);
    end
  end

  // apb decode; writes land at the access edge, read data is prepared in setup
  always_comb begin
    wr_en = psel_in && penable_in && pwrite_in && st_reg.pready;
    rd_setup = psel_in && !penable_in;
    wr_protect = wr_en && (paddr_in == supply_monitor_pkg::PROTECT_OFF);
    wr_clk = wr_en && (paddr_in == supply_monitor_pkg::CLK_CTRL_OFF) && st_reg.unlocked;
    wr_ctrl = wr_en && (paddr_in == supply_monitor_pkg::CTRL_OFF) && st_reg.unlocked;
    wr_flag = wr_en && (paddr_in == supply_monitor_pkg::FLAG_OFF);
    wr_irq_en = wr_en && (paddr_in == supply_monitor_pkg::IRQ_EN_OFF);
    mapped = 1'b1;
    rd_word = supply_monitor_pkg::ZERO_WORD;
    case (paddr_in)
      supply_monitor_pkg::PROTECT_OFF: rd_word[0] = st_reg.unlocked;
      supply_monitor_pkg::CLK_CTRL_OFF: begin
        rd_word[supply_monitor_pkg::CLK_SRC_LSB +: 2] = st_reg.clock_source_sel;
        rd_word[supply_monitor_pkg::CLK_DIV_LSB +: 3] = st_reg.clock_divider_sel;
        rd_word[supply_monitor_pkg::DEBUG_RUN_BIT] = st_reg.debug_run;
      end
      supply_monitor_pkg::CTRL_OFF: begin
        rd_word[supply_monitor_pkg::DETECT_EN_BIT] = st_reg.detect_enable;
        rd_word[supply_monitor_pkg::MODE_LSB +: 2] = st_reg.sampling_mode_sel;
        rd_word[supply_monitor_pkg::RESET_SEL_LSB +: 4] = st_reg.reset_or_irq_sel;
        rd_word[supply_monitor_pkg::THRESH_LSB +: 5] = st_reg.threshold_sel;
        rd_word[supply_monitor_pkg::COUNT_LSB +: 2] = st_reg.low_count_sel;
        rd_word[supply_monitor_pkg::TARGET_BIT] = st_reg.sense_target_sel;
      end
      supply_monitor_pkg::FLAG_OFF: begin
        rd_word[supply_monitor_pkg::FLAG_BIT] = st_reg.low_supply_flag;
        rd_word[supply_monitor_pkg::LIVE_BIT] = st_reg.live_low_result;
      end
      supply_monitor_pkg::IRQ_EN_OFF: rd_word[supply_monitor_pkg::IRQ_EN_BIT] = st_reg.low_supply_irq_enable;
      default: mapped = 1'b0;
    endcase
  end

  // next state
  always_comb begin
    st_next = st_reg;
    // bus handshake: no wait states, ready in the first access cycle
    st_next.pready = rd_setup;
    st_next.pslverr = rd_setup && !mapped;
    if (rd_setup && !pwrite_in) begin
      st_next.prdata = rd_word;
    end
    if (wr_protect) begin
      st_next.unlocked = (pwdata_in[15:0] == supply_monitor_pkg::UNLOCK_KEY);
    end
    if (wr_clk) begin
      st_next.clock_source_sel = pwdata_in[supply_monitor_pkg::CLK_SRC_LSB +: 2];
      st_next.clock_divider_sel = pwdata_in[supply_monitor_pkg::CLK_DIV_LSB +: 3];
      st_next.debug_run = pwdata_in[supply_monitor_pkg::DEBUG_RUN_BIT];
    end
    if (wr_ctrl) begin
      st_next.detect_enable = pwdata_in[supply_monitor_pkg::DETECT_EN_BIT];
      st_next.sampling_mode_sel = pwdata_in[supply_monitor_pkg::MODE_LSB +: 2];
      st_next.reset_or_irq_sel = pwdata_in[supply_monitor_pkg::RESET_SEL_LSB +: 4];
      // codes beyond the last level saturate so the comparator never sees a bad code
      if (pwdata_in[supply_monitor_pkg::THRESH_LSB +: 5] > supply_monitor_pkg::THRESH_MAX) begin
        st_next.threshold_sel = supply_monitor_pkg::THRESH_MAX;
      end else begin
        st_next.threshold_sel = pwdata_in[supply_monitor_pkg::THRESH_LSB +: 5];
      end
      st_next.low_count_sel = pwdata_in[supply_monitor_pkg::COUNT_LSB +: 2];
      st_next.sense_target_sel = pwdata_in[supply_monitor_pkg::TARGET_BIT];
      st_next.low_cnt = 4'h0;
      st_next.interval_cnt = 8'h00;
      st_next.in_slot = 1'b0;
    end
    if (wr_irq_en) begin
      st_next.low_supply_irq_enable = pwdata_in[supply_monitor_pkg::IRQ_EN_BIT];
    end
    // two-flop synchroniser; only the second stage is looked at
    st_next.sync_stage1 = comp_low_in;
    st_next.sync_stage2 = st_reg.sync_stage1;
    // divider advances only on gated source ticks, so sleep and debug freeze it
    if (src_tick && clock_run) begin
      st_next.div_cnt = mon_tick ? 7'h00 : 7'(st_reg.div_cnt + 7'h01);
    end
    // intermittent slot timing on the monitor clock
    if (st_reg.detect_enable && mon_tick
        && st_reg.sampling_mode_sel != supply_monitor_pkg::MODE_CONTINUOUS) begin
      if (st_reg.in_slot) begin
        st_next.slot_cnt = 8'(st_reg.slot_cnt + 8'h01);
        if (sample) begin
          st_next.in_slot = 1'b0;
          st_next.slot_cnt = 8'h00;
        end
      end else if (8'(st_reg.interval_cnt + 8'h01) >= interval) begin
        st_next.interval_cnt = 8'h00;
        st_next.in_slot = 1'b1;
        st_next.slot_cnt = 8'h00;
      end else begin
        st_next.interval_cnt = 8'(st_reg.interval_cnt + 8'h01);
      end
    end
    if (sample) begin
      st_next.live_low_result = st_reg.sync_stage2;
      if (!st_reg.sync_stage2) begin
        st_next.low_cnt = 4'h0;
      end else if (detect) begin
        st_next.low_cnt = 4'h0;
      end else begin
        st_next.low_cnt = 4'(st_reg.low_cnt + 4'h1);
      end
      // reset state ends when the supply reads normal again
      if (st_reg.in_reset && !st_reg.sync_stage2) begin
        st_next.in_reset = 1'b0;
      end
    end
    // flag: write 1 clears, but a detection in the same cycle wins
    if (wr_flag && pwdata_in[supply_monitor_pkg::FLAG_BIT]) begin
      st_next.low_supply_flag = 1'b0;
    end
    if (detect) begin
      st_next.low_supply_flag = 1'b1;
      if (st_reg.reset_or_irq_sel == supply_monitor_pkg::RESET_SEL_KEY) begin
        // reset state: continuous mode, count and enable cleared, clock back to defaults
        st_next.in_reset = 1'b1;
        st_next.sampling_mode_sel = supply_monitor_pkg::MODE_CONTINUOUS;
        st_next.low_count_sel = 2'h0;
        st_next.low_supply_irq_enable = 1'b0;
        st_next.clock_source_sel = supply_monitor_pkg::CLK_SRC_RESET;
        st_next.clock_divider_sel = supply_monitor_pkg::CLK_DIV_RESET;
        st_next.debug_run = supply_monitor_pkg::DEBUG_RUN_RESET;
        st_next.div_cnt = 7'h00;
        st_next.in_slot = 1'b0;
      end
    end
    // comparator powered only with detection enabled: always in continuous mode, only inside slots otherwise
    st_next.comp_enable = st_next.detect_enable
      && (st_next.sampling_mode_sel == supply_monitor_pkg::MODE_CONTINUOUS || st_next.in_slot);
    st_next.irq = st_next.low_supply_flag && st_next.low_supply_irq_enable
      && (st_next.reset_or_irq_sel != supply_monitor_pkg::RESET_SEL_KEY);
  end

  // state register
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
      st_reg.debug_run <= supply_monitor_pkg::DEBUG_RUN_RESET;
      st_reg.clock_source_sel <= supply_monitor_pkg::CLK_SRC_RESET;
      st_reg.clock_divider_sel <= supply_monitor_pkg::CLK_DIV_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign prdata_out = st_reg.prdata;
  assign pready_out = st_reg.pready;
  assign pslverr_out = st_reg.pslverr;
  assign comp_enable_out = st_reg.comp_enable;
  assign sense_target_out = st_reg.sense_target_sel;
  assign threshold_sel_out = st_reg.threshold_sel;
  assign irq_out = st_reg.irq;
  assign reset_req_out = st_reg.in_reset;
endmodule : supply_monitor
`default_nettype wire

// ---- supply_monitor_assertions.sv ----
// port checker for the supply monitor
// bound from the bench top; sees only the top module's ports
`timescale 1ns/10ps
`default_nettype none
module supply_monitor_assertions (
  input wire logic mclk_in, // clock
  input wire logic rst_n_in, // reset, active low
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  input wire logic pwrite_in, // apb direction
  input wire logic [7:0] paddr_in, // apb address
  input wire logic [31:0] pwdata_in, // apb write data
  input wire logic pready_out, // apb ready
  input wire logic pslverr_out, // apb error
  input wire logic comp_enable_out, // comparator power
  input wire logic [4:0] threshold_sel_out, // threshold code
  input wire logic irq_out, // interrupt request
  input wire logic reset_req_out // reset request
);
  logic open_reg; // protection removed
  logic [1:0] mode_reg; // accepted sampling mode
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence wr_s(a);
    psel_in && penable_in && pready_out && pwrite_in && paddr_in == a;
  endsequence
  // shadow of lock and mode; a reset state forces continuous sampling
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      open_reg <= 1'b0;
      mode_reg <= 2'h0;
    end else if (reset_req_out) begin
      mode_reg <= 2'h0;
    end else if (psel_in && penable_in && pready_out && pwrite_in) begin
      if (paddr_in == supply_monitor_pkg::PROTECT_OFF) open_reg <= pwdata_in[15:0] == supply_monitor_pkg::UNLOCK_KEY;
      if (paddr_in == supply_monitor_pkg::CTRL_OFF && open_reg) mode_reg <= pwdata_in[2:1];
    end
  end
  AST_READY_AFTER_SETUP: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready after setup");
  AST_READY_ONLY_ACCESS: assert property (pready_out |-> $past(psel_in) && !$past(penable_in))
    else $error("ready outside access");
  AST_SLVERR_UNMAPPED: assert property (psel_in && !penable_in && paddr_in > 8'h10 |=> pslverr_out && pready_out)
    else $error("unmapped access not refused");
  AST_THRESH_FOLLOWS: assert property (wr_s(supply_monitor_pkg::CTRL_OFF) ##0 (open_reg && pwdata_in[12:8] < 5'h14)
    |-> ##2 threshold_sel_out == $past(pwdata_in[12:8], 2))
    else $error("threshold code not driven");
  AST_THRESH_SAT: assert property (wr_s(supply_monitor_pkg::CTRL_OFF) ##0 (open_reg && pwdata_in[12:8] > 5'h13)
    |-> ##2 threshold_sel_out == supply_monitor_pkg::THRESH_MAX)
    else $error("threshold code not saturated");
  AST_ONE_REQUEST: assert property (!(irq_out && reset_req_out))
    else $error("interrupt and reset together");
  AST_IRQ_OFF_AFTER_DISABLE: assert property (wr_s(supply_monitor_pkg::IRQ_EN_OFF) ##0 !pwdata_in[0] |-> ##2 !irq_out)
    else $error("interrupt stays after disable");
  AST_SLOT_CLOSES: assert property (mode_reg != 2'h0 && $rose(comp_enable_out)
    |-> ##[1:40] (!comp_enable_out || reset_req_out))
    else $error("comparator left powered");
endmodule : supply_monitor_assertions
`default_nettype wire

// ---- supply_monitor_partner.sv ----
// far side model: four clock source ticks and the analog comparator
// assumes the bench sets supply and pin levels as threshold codes
`timescale 1ns/10ps
`default_nettype none
module supply_monitor_partner (
  input wire logic mclk_in, // clock
  input wire logic rst_n_in, // reset, active low
  input wire logic comp_enable_in, // comparator power
  input wire logic sense_target_in, // 0 supply, 1 pin
  input wire logic [4:0] threshold_sel_in, // level code
  input wire logic [4:0] vdd_lvl_in, // supply level code
  input wire logic [4:0] pin_lvl_in, // pin level code
  output logic [3:0] src_tick_out, // one-cycle source ticks
  output logic comp_low_out // 1 when below threshold
);
  logic [2:0] phase_reg; // tick phase
  logic last_reg; // last comparator output
  // each source ticks once in eight clocks, phases staggered
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_reg <= 3'h0;
      last_reg <= 1'b0;
    end else begin
      phase_reg <= phase_reg + 3'h1;
      last_reg <= comp_low_out;
    end
  end
  always_comb begin
    src_tick_out = 4'h0;
    if (!phase_reg[2]) src_tick_out[phase_reg[1:0]] = 1'b1;
  end
  // unpowered comparator output is meaningless, so it toggles
  assign comp_low_out = comp_enable_in ? ((sense_target_in ? pin_lvl_in : vdd_lvl_in) < threshold_sel_in) : ~last_reg;
endmodule : supply_monitor_partner
`default_nettype wire

// ---- supply_monitor_pkg.sv ----
// constants for the supply monitor control block: register map, field layout,
// reset values, sampling intervals and the protection key.
// assumes a 32-bit APB register bus and a clock generator that delivers source ticks.
package supply_monitor_pkg;
  // register byte offsets
  localparam logic [7:0] PROTECT_OFF = 8'h00;
  localparam logic [7:0] CLK_CTRL_OFF = 8'h04;
  localparam logic [7:0] CTRL_OFF = 8'h08;
  localparam logic [7:0] FLAG_OFF = 8'h0C;
  localparam logic [7:0] IRQ_EN_OFF = 8'h10;
  // protection
  localparam logic [15:0] UNLOCK_KEY = 16'h0096;
  // clock control fields
  localparam int CLK_SRC_LSB = 0;
  localparam int CLK_DIV_LSB = 4;
  localparam int DEBUG_RUN_BIT = 8;
  localparam logic [1:0] CLK_SRC_RESET = 2'h0;
  localparam logic [2:0] CLK_DIV_RESET = 3'h0;
  localparam logic DEBUG_RUN_RESET = 1'b1;
  // monitor control fields
  localparam int DETECT_EN_BIT = 0;
  localparam int MODE_LSB = 1;
  localparam int RESET_SEL_LSB = 4;
  localparam int THRESH_LSB = 8;
  localparam int COUNT_LSB = 13;
  localparam int TARGET_BIT = 15;
  // flag and interrupt enable register fields
  localparam int FLAG_BIT = 0;
  localparam int LIVE_BIT = 8;
  localparam int IRQ_EN_BIT = 0;
  // encodings
  localparam logic [1:0] MODE_CONTINUOUS = 2'h0;
  localparam logic [3:0] RESET_SEL_KEY = 4'hA;
  localparam int THRESHOLD_LEVELS = 20;
  localparam logic [4:0] THRESH_MAX = 5'(THRESHOLD_LEVELS - 1);
  // intermittent intervals in monitor clock ticks for modes 1..3
  localparam logic [7:0] INTERVAL_MODE1 = 8'h20;
  localparam logic [7:0] INTERVAL_MODE2 = 8'h40;
  localparam logic [7:0] INTERVAL_MODE3 = 8'h80;
  // comparator power-up ticks before a sample is taken
  localparam logic [7:0] SETTLE_TICKS = 8'h01;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage : supply_monitor_pkg

// ---- test_supply_monitor.sv ----
// self-checking bench: apb master, register model, partner on the far side
// assumes the partner gives source ticks every eight clocks
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; $display("wrong value at %0t: %h expected %h", $time, g, e); end end
module test_supply_monitor;
  logic mclk_in = 1'b0, rst_n_in = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep = 1'b0, debug = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic [3:0] tick, sleep_stop = 4'h0;
  logic [4:0] thr, vdd = 5'h0A, pin = 5'h0A;
  logic pready, pslverr, err, comp_low, comp_en, target, irq, rreq, unlocked = 1'b0;
  logic [31:0] exp_q [5];
  int miscompares = 0, tests_run = 0;
  integer seed = 32'hA3E6;
  always #5 mclk_in = ~mclk_in;
  supply_monitor DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .src_tick_in(tick), .source_sleep_stop_in(sleep_stop), .sleep_in(sleep),
    .debug_in(debug), .comp_low_in(comp_low), .comp_enable_out(comp_en), .sense_target_out(target),
    .threshold_sel_out(thr), .irq_out(irq), .reset_req_out(rreq));
  supply_monitor_partner u_far (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .comp_enable_in(comp_en),
    .sense_target_in(target), .threshold_sel_in(thr), .vdd_lvl_in(vdd), .pin_lvl_in(pin),
    .src_tick_out(tick), .comp_low_out(comp_low));
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : cyc
  // one transfer; the request holds until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    do @(posedge mclk_in); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // write, then update the register model
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    case (a)
      8'h00: begin unlocked = d[15:0] == 16'h0096; exp_q[0] = {31'h0, unlocked}; end
      8'h04: if (unlocked) exp_q[1] = d & 32'h0000_0173;
      8'h08: if (unlocked) exp_q[2] = {16'h0, d[15:13], (d[12:8] > 5'h13) ? 5'h13 : d[12:8], d[7:4], 1'b0, d[2:0]};
      8'h0C: if (d[0]) exp_q[3][0] = 1'b0;
      8'h10: exp_q[4] = {31'h0, d[0]};
      default: `CHK(err, 1'b1)
    endcase
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    `CHK(rdata, (a > 8'h10) ? 32'h0 : exp_q[a[4:2]])
    if (a > 8'h10) `CHK(err, 1'b1)
  endtask : rd
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  // watchdog: the full run needs about 8000 cycles; 20000 cycles leaves margin and stays bounded
  initial begin
    #200000;
    miscompares++;
    stop_test();
  end
  initial begin
    exp_q = '{32'h0, 32'h100, 32'h0, 32'h0, 32'h0};
    cyc(10);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 6; i++) rd(8'(i * 4));
    wr(8'h08, 32'h1F00); rd(8'h08);
    wr(8'h00, 32'h0096);
    for (int i = 0; i < 6; i++) begin
      wr(8'h08, ($random(seed) & 32'hFFFE) | ((i == 0) ? 32'h1F00 : 32'h0));
      rd(8'h08);
      cyc(3);
      `CHK(thr, exp_q[2][12:8])
      `CHK(target, exp_q[2][15])
    end
    $display("done registers");
    wr(8'h10, 32'h1); wr(8'h0C, 32'h1);
    // gated by debug, gated by sleep, then running through debug
    for (int g = 0; g < 3; g++) begin
      wr(8'h04, (g == 2) ? 32'h101 : 32'h1);
      wr(8'h08, (g == 1) ? 32'h8501 : 32'h0501);
      sleep_stop <= 4'h2; debug <= g != 1; sleep <= g == 1;
      if (g == 1) pin <= 5'h02; else vdd <= 5'h02;
      cyc(60);
      if (g == 2) exp_q[3] = 32'h101;
      rd(8'h0C);
      `CHK(irq, exp_q[3][0])
      debug <= 1'b0; sleep <= 1'b0;
      cyc(60);
      exp_q[3] = 32'h101;
      rd(8'h0C);
      vdd <= 5'h0A; pin <= 5'h0A;
      cyc(60);
      exp_q[3] = 32'h1;
      rd(8'h0C);
      wr(8'h10, 32'h0); cyc(3); `CHK(irq, 1'b0)
      wr(8'h10, 32'h1); wr(8'h0C, 32'h1); rd(8'h0C);
      cyc(3); `CHK(irq, 1'b0)
    end
    $display("done continuous");
    vdd <= 5'h02;
    for (int m = 1; m < 4; m++) begin
      wr(8'h08, 32'h0501 | (m << 1) | ((m - 1) << 13));
      wr(8'h0C, 32'h1);
      cyc((16 << m) * 8 * (1 << (m - 1)) - (16 << m) * 4);
      apb(1'b0, 8'h0C, 32'h0); `CHK(rdata[0], 1'b0)
      cyc((16 << m) * 8);
      apb(1'b0, 8'h0C, 32'h0); `CHK(rdata[0], 1'b1)
    end
    $display("done intermittent");
    wr(8'h08, 32'h05A3);
    cyc(400);
    `CHK(rreq, 1'b1)
    `CHK(irq, 1'b0)
    exp_q = '{32'h1, 32'h100, 32'h05A1, 32'h101, 32'h0};
    for (int i = 1; i < 5; i++) rd(8'(i * 4));
    vdd <= 5'h0A;
    cyc(100);
    `CHK(rreq, 1'b0)
    $display("done reset mode");
    stop_test();
  end
endmodule : test_supply_monitor
bind supply_monitor supply_monitor_assertions u_chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .comp_enable_out(comp_enable_out),
  .threshold_sel_out(threshold_sel_out), .irq_out(irq_out), .reset_req_out(reset_req_out));
`default_nettype wire
